// ===== fser_consts.vh
// constants for the flash status/error host controller
`ifndef FSER_CONSTS_VH
`define FSER_CONSTS_VH
// widths
`define FSER_AW          26
`define FSER_DW          16
// own register offsets (byte addresses)
`define FSER_CTRL_OFF    8'h00
`define FSER_ADDR_OFF    8'h04
`define FSER_WDATA_OFF   8'h08
`define FSER_RDATA_OFF   8'h0C
`define FSER_STAT_OFF    8'h10
`define FSER_SREG_OFF    8'h14
`define FSER_SUSP_OFF    8'h18
// control fields
`define FSER_CTRL_GO     0
`define FSER_CTRL_OP_LO  1
`define FSER_CTRL_OP_HI  3
`define FSER_CTRL_AUTO   4
`define FSER_CTRL_RST    5'h00
// operations
`define FSER_OP_READ     3'h1
`define FSER_OP_CMD      3'h2
`define FSER_OP_POLL     3'h3
`define FSER_OP_SRREAD   3'h4
// polling bit positions on the data bus
`define FSER_DATA_POLL   7
`define FSER_TOGGLE_ONE  6
`define FSER_TIMEOUT     5
`define FSER_ERASE_START 3
`define FSER_SECT_TOGGLE 2
`define FSER_BUF_ABORT   1
// status register bits
`define FSER_SR_VALID    7
`define FSER_SR_ERASE    5
`define FSER_SR_PROG     4
`define FSER_SR_ABORT    3
`define FSER_SR_PROT     1
// reserved bits masked before use
`define FSER_POLL_MASK   16'hFFEE
`define FSER_SR_MASK     8'hFE
// command codes (values arbitrary, replace for the real part)
`define FSER_CMD_RESET   16'h00A1
`define FSER_CMD_SRCLR   16'h00A2
`define FSER_CMD_SRREAD  16'h00A3
`define FSER_CMD_ABRST   16'h00A4
// error classes held by the host
`define FSER_ERR_NONE    2'h0
`define FSER_ERR_EMB     2'h1
`define FSER_ERR_ABORT   2'h2
`define FSER_ERR_PROT    2'h3
// bus cycle timing in clock cycles
`define FSER_STROBE_CYC  4'h4
// post-reset busy window: 2 us at 8 ns
`define FSER_RST_BUSY_NS 2000
`define FSER_CLK_NS      8
`define FSER_RST_BUSY_CYC ((`FSER_RST_BUSY_NS + `FSER_CLK_NS - 1) / `FSER_CLK_NS)
// program-suspended line granule, low address bits ignored
`define FSER_LINE_BITS   8
`endif

// ===== fser_cycle.v
// one asynchronous read or write bus cycle on the flash pins
`include "fser_consts.vh"
module fser_cycle (
  // clock and reset
  input  wire                 pclk,
  input  wire                 presetn,
  // request
  input  wire                 start,
  input  wire                 wr,
  input  wire [`FSER_AW-1:0]  addr,
  input  wire [`FSER_DW-1:0]  wdata,
  output reg                  done_r,
  output reg  [`FSER_DW-1:0]  rdata_r,
  // flash pins
  output reg                  chip_enable_n_r,
  output reg                  output_enable_n_r,
  output reg                  write_enable_n_r,
  output reg  [`FSER_AW-1:0]  flash_addr_r,
  output reg  [`FSER_DW-1:0]  dq_out_r,
  output reg                  dq_oe_r,
  input  wire [`FSER_DW-1:0]  dq_in
);
  localparam P_IDLE   = 3'b001;
  localparam P_SETUP  = 3'b010;
  localparam P_STROBE = 3'b100;

  reg [2:0] phase_r;
  reg [3:0] cnt_r;
  reg       wr_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r           <= P_IDLE;
      cnt_r             <= 4'h0;
      wr_r              <= 1'b0;
      done_r            <= 1'b0;
      rdata_r           <= 16'h0000;
      chip_enable_n_r   <= 1'b1;
      output_enable_n_r <= 1'b1;
      write_enable_n_r  <= 1'b1;
      flash_addr_r      <= 26'h0000000;
      dq_out_r          <= 16'h0000;
      dq_oe_r           <= 1'b0;
    end else begin
      done_r <= 1'b0;
      case (phase_r)
        P_IDLE: begin
          if (start) begin
            phase_r         <= P_SETUP;
            wr_r            <= wr;
            flash_addr_r    <= addr;
            dq_out_r        <= wdata;
            dq_oe_r         <= wr;
            chip_enable_n_r <= 1'b0;
          end
        end
        P_SETUP: begin
          phase_r           <= P_STROBE;
          cnt_r             <= `FSER_STROBE_CYC;
          output_enable_n_r <= wr_r;
          write_enable_n_r  <= ~wr_r;
        end
        P_STROBE: begin
          if (cnt_r == 4'h1) begin
            // each read ends with oe and ce released, so the next read is a new toggle cycle
            if (!wr_r)
              rdata_r <= dq_in;
            phase_r           <= P_IDLE;
            done_r            <= 1'b1;
            chip_enable_n_r   <= 1'b1;
            output_enable_n_r <= 1'b1;
            write_enable_n_r  <= 1'b1;
            dq_oe_r           <= 1'b0;
          end
          cnt_r <= cnt_r - 4'h1;
        end
        default: phase_r <= P_IDLE;
      endcase
    end
  end
endmodule // fser_cycle

// ===== fser_host.v
// host controller: status polling and error handling for a parallel nor flash
//
// Our own choices: the address map and the APB interface to the registers.
`include "fser_consts.vh"
module fser_host (
  // clock and reset
  input  wire                 pclk,
  input  wire                 presetn,
  // apb slave
  input  wire                 psel,
  input  wire                 penable,
  input  wire                 pwrite,
  input  wire [7:0]           paddr,
  input  wire [31:0]          pwdata,
  output reg  [31:0]          prdata,
  output wire                 pready,
  output wire                 pslverr,
  // flash pins
  output wire                 chip_enable_n,
  output wire                 output_enable_n,
  output wire                 write_enable_n,
  output wire [`FSER_AW-1:0]  flash_addr,
  output wire [`FSER_DW-1:0]  dq_out,
  output wire                 dq_oe,
  input  wire [`FSER_DW-1:0]  dq_in,
  input  wire                 ready_busy_n
);
  localparam S_IDLE = 6'b000001;
  localparam S_RDA  = 6'b000010;
  localparam S_RDB  = 6'b000100;
  localparam S_WR   = 6'b001000;
  localparam S_HOLD = 6'b010000;
  localparam S_SRRD = 6'b100000;

  reg [5:0]          state_r;
  reg [4:0]          ctrl_r;
  reg [`FSER_AW-1:0] addr_r;
  reg [15:0]         wdata_r;
  reg [15:0]         rdata_r;
  reg [7:0]          sreg_r;
  reg [`FSER_AW:0]   susp_r;
  reg                busy_r;
  reg                done_r;
  reg                toggling_r;
  reg                timeout_r;
  reg                abort_r;
  reg                refused_r;
  reg                sr_valid_r;
  reg [1:0]          err_r;
  reg                recheck_r;
  reg [15:0]         first_r;
  reg [8:0]          hold_r;
  reg                cyc_start_r;
  reg                cyc_wr_r;
  reg [15:0]         cyc_data_r;
  wire               cyc_done;
  wire [15:0]        cyc_rdata;

  wire [2:0] op_w  = ctrl_r[`FSER_CTRL_OP_HI:`FSER_CTRL_OP_LO];
  wire       apb_w = psel & penable & pwrite;
  wire       mapped = (paddr <= `FSER_SUSP_OFF) && (paddr[1:0] == 2'b00);
  wire       go_w  = apb_w && (paddr == `FSER_CTRL_OFF) && pwdata[`FSER_CTRL_GO] && !busy_r;
  wire [2:0] go_op = pwdata[`FSER_CTRL_OP_HI:`FSER_CTRL_OP_LO];
  // reserved polling bits never take part in decisions
  wire [15:0] poll_w = cyc_rdata & `FSER_POLL_MASK;
  wire [15:0] first_m = first_r & `FSER_POLL_MASK;
  wire        susp_hit = susp_r[0] &&
    (addr_r[`FSER_AW-1:`FSER_LINE_BITS] == susp_r[`FSER_AW:`FSER_LINE_BITS+1]);
  // commands allowed under each held error class
  reg cmd_ok;
  always @* begin
    case (err_r)
      `FSER_ERR_EMB:   cmd_ok = (wdata_r == `FSER_CMD_SRREAD) || (wdata_r == `FSER_CMD_RESET) ||
                                (wdata_r == `FSER_CMD_SRCLR);
      `FSER_ERR_ABORT: cmd_ok = (wdata_r == `FSER_CMD_SRREAD) || (wdata_r == `FSER_CMD_ABRST) ||
                                (wdata_r == `FSER_CMD_SRCLR);
      `FSER_ERR_PROT:  cmd_ok = (wdata_r == `FSER_CMD_SRREAD) || ready_busy_n;
      default:         cmd_ok = 1'b1;
    endcase
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always @* begin
    case (paddr)
      `FSER_CTRL_OFF:  prdata = {27'h0000000, ctrl_r[4:1], 1'b0};
      `FSER_ADDR_OFF:  prdata = {6'h00, addr_r};
      `FSER_WDATA_OFF: prdata = {16'h0000, wdata_r};
      `FSER_RDATA_OFF: prdata = {16'h0000, rdata_r};
      `FSER_STAT_OFF:  prdata = {22'h000000, err_r, sr_valid_r, ready_busy_n, refused_r,
                                 abort_r, timeout_r, toggling_r, done_r, busy_r};
      `FSER_SREG_OFF:  prdata = {24'h000000, sreg_r};
      `FSER_SUSP_OFF:  prdata = {5'h00, susp_r};
      default:         prdata = 32'h00000000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r     <= S_IDLE;
      ctrl_r      <= `FSER_CTRL_RST;
      addr_r      <= 26'h0000000;
      wdata_r     <= 16'h0000;
      rdata_r     <= 16'h0000;
      sreg_r      <= 8'h00;
      susp_r      <= 27'h0000000;
      busy_r      <= 1'b0;
      done_r      <= 1'b0;
      toggling_r  <= 1'b0;
      timeout_r   <= 1'b0;
      abort_r     <= 1'b0;
      refused_r   <= 1'b0;
      sr_valid_r  <= 1'b0;
      err_r       <= `FSER_ERR_NONE;
      recheck_r   <= 1'b0;
      first_r     <= 16'h0000;
      hold_r      <= 9'h000;
      cyc_start_r <= 1'b0;
      cyc_wr_r    <= 1'b0;
      cyc_data_r  <= 16'h0000;
    end else begin
      cyc_start_r <= 1'b0;
      if (apb_w && !busy_r) begin
        if (paddr == `FSER_CTRL_OFF)
          ctrl_r <= {pwdata[4:1], 1'b0};
        if (paddr == `FSER_ADDR_OFF)
          addr_r <= pwdata[`FSER_AW-1:0];
        if (paddr == `FSER_WDATA_OFF)
          wdata_r <= pwdata[15:0];
        if (paddr == `FSER_SUSP_OFF)
          susp_r <= pwdata[`FSER_AW:0];
      end
      case (state_r)
        S_IDLE: begin
          if (go_w) begin
            done_r    <= 1'b0;
            refused_r <= 1'b0;
            recheck_r <= 1'b0;
            busy_r    <= 1'b1;
            if (go_op == `FSER_OP_READ && susp_hit) begin
              refused_r <= 1'b1;
              done_r    <= 1'b1;
              busy_r    <= 1'b0;
            end else if (go_op == `FSER_OP_READ || go_op == `FSER_OP_POLL) begin
              // polling uses the address software supplied, sector or last word
              cyc_start_r <= 1'b1;
              cyc_wr_r    <= 1'b0;
              state_r     <= S_RDA;
            end else if (go_op == `FSER_OP_CMD && !cmd_ok) begin
              refused_r <= 1'b1;
              done_r    <= 1'b1;
              busy_r    <= 1'b0;
            end else if (go_op == `FSER_OP_CMD || go_op == `FSER_OP_SRREAD) begin
              cyc_start_r <= 1'b1;
              cyc_wr_r    <= 1'b1;
              cyc_data_r  <= (go_op == `FSER_OP_SRREAD) ? `FSER_CMD_SRREAD : wdata_r;
              state_r     <= S_WR;
            end else begin
              done_r <= 1'b1;
              busy_r <= 1'b0;
            end
          end
        end
        S_RDA: begin
          if (cyc_done) begin
            first_r <= cyc_rdata;
            rdata_r <= cyc_rdata;
            if (op_w == `FSER_OP_READ) begin
              done_r  <= 1'b1;
              busy_r  <= 1'b0;
              state_r <= S_IDLE;
            end else begin
              // second read of the pair; its strobe is a new read cycle
              cyc_start_r <= 1'b1;
              state_r     <= S_RDB;
            end
          end
        end
        S_RDB: begin
          if (cyc_done) begin
            rdata_r <= cyc_rdata;
            if (poll_w[`FSER_TOGGLE_ONE] == first_m[`FSER_TOGGLE_ONE]) begin
              toggling_r <= 1'b0;
              timeout_r  <= 1'b0;
              abort_r    <= 1'b0;
              done_r     <= 1'b1;
              busy_r     <= 1'b0;
              state_r    <= S_IDLE;
            end else if (poll_w[`FSER_TIMEOUT] && !recheck_r) begin
              // toggle may stop just as the timeout bit rises: look once more
              recheck_r   <= 1'b1;
              cyc_start_r <= 1'b1;
              state_r     <= S_RDA;
            end else if (poll_w[`FSER_TIMEOUT] || poll_w[`FSER_BUF_ABORT]) begin
              toggling_r  <= 1'b1;
              timeout_r   <= poll_w[`FSER_TIMEOUT];
              abort_r     <= poll_w[`FSER_BUF_ABORT] & ~poll_w[`FSER_TIMEOUT];
              err_r       <= poll_w[`FSER_TIMEOUT] ? `FSER_ERR_EMB : `FSER_ERR_ABORT;
              if (ctrl_r[`FSER_CTRL_AUTO]) begin
                cyc_start_r <= 1'b1;
                cyc_wr_r    <= 1'b1;
                cyc_data_r  <= poll_w[`FSER_TIMEOUT] ? `FSER_CMD_RESET : `FSER_CMD_ABRST;
                state_r     <= S_WR;
              end else begin
                done_r  <= 1'b1;
                busy_r  <= 1'b0;
                state_r <= S_IDLE;
              end
            end else begin
              // still running; keep comparing pairs until the toggle-one bit settles or the timeout or abort bit shows
              toggling_r  <= 1'b1;
              cyc_start_r <= 1'b1;
              state_r     <= S_RDA;
            end
          end
        end
        S_WR: begin
          if (cyc_done) begin
            if (cyc_data_r == `FSER_CMD_SRREAD) begin
              cyc_start_r <= 1'b1;
              cyc_wr_r    <= 1'b0;
              state_r     <= S_SRRD;
            end else if (cyc_data_r == `FSER_CMD_RESET || cyc_data_r == `FSER_CMD_SRCLR ||
                         cyc_data_r == `FSER_CMD_ABRST) begin
              err_r     <= `FSER_ERR_NONE;
              timeout_r <= 1'b0;
              abort_r   <= 1'b0;
              hold_r    <= 9'd0;
              state_r   <= S_HOLD;
            end else begin
              done_r  <= 1'b1;
              busy_r  <= 1'b0;
              state_r <= S_IDLE;
            end
          end
        end
        S_HOLD: begin
          // device may still show busy this long after a reset
          hold_r <= hold_r + 9'd1;
          if (hold_r == `FSER_RST_BUSY_CYC - 1) begin
            done_r  <= 1'b1;
            busy_r  <= 1'b0;
            state_r <= S_IDLE;
          end
        end
        S_SRRD: begin
          if (cyc_done) begin
            sreg_r     <= cyc_rdata[7:0] & `FSER_SR_MASK;
            sr_valid_r <= cyc_rdata[`FSER_SR_VALID];
            done_r     <= 1'b1;
            busy_r     <= 1'b0;
            state_r    <= S_IDLE;
            if (!cyc_rdata[`FSER_SR_VALID] && !ready_busy_n)
              err_r <= `FSER_ERR_PROT;
            else if (cyc_rdata[`FSER_SR_VALID] && cyc_rdata[`FSER_SR_ABORT])
              err_r <= `FSER_ERR_ABORT;
            else if (cyc_rdata[`FSER_SR_VALID] && cyc_rdata[`FSER_SR_PROT])
              err_r <= `FSER_ERR_NONE;
            else if (cyc_rdata[`FSER_SR_VALID] && !ready_busy_n &&
                     (cyc_rdata[`FSER_SR_ERASE] || cyc_rdata[`FSER_SR_PROG]))
              err_r <= `FSER_ERR_EMB;
            else if (err_r == `FSER_ERR_PROT)
              err_r <= `FSER_ERR_NONE;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  fser_cycle u_cycle (
    .pclk              (pclk),
    .presetn           (presetn),
    .start             (cyc_start_r),
    .wr                (cyc_wr_r),
    .addr              (addr_r),
    .wdata             (cyc_data_r),
    .done_r            (cyc_done),
    .rdata_r           (cyc_rdata),
    .chip_enable_n_r   (chip_enable_n),
    .output_enable_n_r (output_enable_n),
    .write_enable_n_r  (write_enable_n),
    .flash_addr_r      (flash_addr),
    .dq_out_r          (dq_out),
    .dq_oe_r           (dq_oe),
    .dq_in             (dq_in)
  );
endmodule // fser_host

// ===== fser_host_sva.sv
// assertions on the apb port and flash pins of the host controller
`include "fser_consts.vh"
module fser_host_sva (
  // clock and reset
  input wire logic                pclk,
  input wire logic                presetn,
  // apb
  input wire logic                psel,
  input wire logic                penable,
  input wire logic [7:0]          paddr,
  input wire logic                pready,
  input wire logic                pslverr,
  // flash pins
  input wire logic                chip_enable_n,
  input wire logic                output_enable_n,
  input wire logic                write_enable_n,
  input wire logic [`FSER_AW-1:0] flash_addr,
  input wire logic                dq_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire bad_addr = (paddr > 8'h18) || (paddr[1:0] != 2'h0);
  property p_ready; psel |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low in transfer");
  property p_slverr; psel && penable |-> (pslverr == bad_addr); endproperty
  a_slverr: assert property (p_slverr) else $error("pslverr does not match address decode");
  property p_read_strobe; $fell(output_enable_n) |-> !output_enable_n [*4] ##[0:1] output_enable_n; endproperty
  a_read_strobe: assert property (p_read_strobe) else $error("read strobe length wrong");
  property p_write_strobe; $fell(write_enable_n) |-> !write_enable_n [*4] ##[0:1] write_enable_n; endproperty
  a_write_strobe: assert property (p_write_strobe) else $error("write strobe length wrong");
  property p_strobe_in_cycle; !output_enable_n || !write_enable_n |-> !chip_enable_n && (output_enable_n || write_enable_n); endproperty
  a_strobe_in_cycle: assert property (p_strobe_in_cycle) else $error("strobe outside chip enable");
  property p_addr_stable; !chip_enable_n && !$past(chip_enable_n) |-> $stable(flash_addr); endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved in cycle");
  property p_idle_gap; $rose(chip_enable_n) |=> chip_enable_n; endproperty
  a_idle_gap: assert property (p_idle_gap) else $error("no idle cycle between flash cycles");
  property p_ce_then_strobe; $fell(chip_enable_n) |=> $fell(output_enable_n) || $fell(write_enable_n); endproperty
  a_ce_then_strobe: assert property (p_ce_then_strobe) else $error("strobe late after chip enable");
  property p_dq_dir; dq_oe |-> output_enable_n && !chip_enable_n; endproperty
  a_dq_dir: assert property (p_dq_dir) else $error("data driven outside write cycle");
  property p_release; $rose(output_enable_n) || $rose(write_enable_n) |-> chip_enable_n && !dq_oe; endproperty
  a_release: assert property (p_release) else $error("pins not released together");
  c_read: cover property ($fell(output_enable_n));
  c_write: cover property ($fell(write_enable_n));
  c_slverr: cover property (psel && penable && pslverr);
endmodule // fser_host_sva
bind fser_host fser_host_sva fser_host_sva_inst (.pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr,
  .chip_enable_n, .output_enable_n, .write_enable_n, .flash_addr, .dq_oe);

// ===== fser_flash_model.sv
// behavioural flash: polling overlay, status register and error clearing
`include "fser_consts.vh"
module fser_flash_model (
  // pins from host
  input  wire logic                chip_enable_n,
  input  wire logic                output_enable_n,
  input  wire logic                write_enable_n,
  input  wire logic [`FSER_AW-1:0] flash_addr,
  input  wire logic [`FSER_DW-1:0] dq_out,
  input  wire logic                dq_oe,
  // back to host
  output logic      [`FSER_DW-1:0] dq_in,
  output logic                     ready_busy_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // 0 array, 1 erase, 2 embedded error, 3 buffer abort, 4 protect busy, 5 protect done, 6 erase suspend
  logic [2:0]  mode = 3'h0;
  logic        tog = 1'b0;
  logic        stog = 1'b0;
  logic        sr_next = 1'b0;
  logic [15:0] last = 16'h0000;
  logic [7:0]  sr;
  logic [15:0] word;
  always_comb begin
    case (mode)
      3'h2: sr = 8'hA0;
      3'h3: sr = 8'h98;
      3'h5: sr = 8'h92;
      default: sr = 8'h00;
    endcase
    if (sr_next)
      word = {8'h00, sr};
    else if (mode == 3'h0 || mode == 3'h5)
      word = flash_addr[15:0] ^ 16'h5A5A;
    else if (mode == 3'h6)
      word = {8'h00, 1'b1, tog, 1'b0, 1'b0, 1'b0, stog, 2'b00};
    else
      word = {8'h00, 1'b0, tog, mode == 3'h2, 1'b0, 1'b1, stog, mode == 3'h3, 1'b0};
  end
  assign ready_busy_n = (mode == 3'h0) || (mode == 3'h5) || (mode == 3'h6);
  // released bus shows the inverse so a late sample never matches by luck
  assign dq_in = (!chip_enable_n && !output_enable_n && !dq_oe) ? word : ~last;
  // ce rises on the same edge as the strobe, so it cannot qualify the strobe edge
  always @(posedge output_enable_n) begin
    last <= word;
    sr_next <= 1'b0;
    if (!ready_busy_n)
      tog <= ~tog;
    if (!ready_busy_n || mode == 3'h6)
      stog <= ~stog;
  end
  always @(posedge write_enable_n) begin
    if (dq_out == `FSER_CMD_SRREAD)
      sr_next <= 1'b1;
    else if (mode == 3'h2 && (dq_out == `FSER_CMD_RESET || dq_out == `FSER_CMD_SRCLR))
      mode <= 3'h0;
    else if (mode == 3'h3 && (dq_out == `FSER_CMD_ABRST || dq_out == `FSER_CMD_SRCLR))
      mode <= 3'h0;
  end
endmodule // fser_flash_model

// ===== testbench.sv
// self-checking bench for the flash status host controller
`include "fser_consts.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {string nm; logic [31:0] exp; logic [31:0] mask; logic err;} fser_note_t;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, note_on = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire pready, pslverr, chip_enable_n, output_enable_n, write_enable_n, dq_oe, ready_busy_n;
  wire [`FSER_AW-1:0] flash_addr;
  wire [`FSER_DW-1:0] dq_out, dq_in;
  fser_note_t notes[$];
  int bad_count = 0, comparisons = 0;
  always #4 pclk = ~pclk;
  fser_host fser_host_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .chip_enable_n, .output_enable_n, .write_enable_n, .flash_addr, .dq_out, .dq_oe, .dq_in,
    .ready_busy_n);
  fser_flash_model fser_flash_model_inst (.chip_enable_n, .output_enable_n, .write_enable_n, .flash_addr,
    .dq_out, .dq_oe, .dq_in, .ready_busy_n);
  task automatic print_verdict();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic chk,
                      output logic [31:0] q);
    int n;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; note_on <= chk;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin bad_count++; print_verdict(); end
    q = prdata;
    psel <= 1'b0; penable <= 1'b0; note_on <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, 1'b0, q);
  endtask
  task automatic check(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                       input logic err);
    logic [31:0] q;
    notes.push_back('{nm, e, m, err});
    xfer(1'b0, a, 32'h0, 1'b1, q);
  endtask
  // start one operation and wait for done with busy low
  task automatic run(input logic [3:0] op, input logic [25:0] a, input logic [15:0] d);
    int n;
    logic [31:0] q;
    wr(`FSER_ADDR_OFF, {6'h00, a});
    wr(`FSER_WDATA_OFF, {16'h0000, d});
    wr(`FSER_CTRL_OFF, {27'h0000000, op, 1'b1});
    n = 0;
    do begin xfer(1'b0, `FSER_STAT_OFF, 32'h0, 1'b0, q); n++; end while (q[1:0] !== 2'b10 && n < 2000);
    if (n >= 2000) begin bad_count++; print_verdict(); end
  endtask
  always @(posedge pclk) if (psel && penable && pready && note_on && notes.size() > 0) begin
    fser_note_t t;
    t = notes.pop_front();
    comparisons++;
    if (((prdata & t.mask) !== (t.exp & t.mask)) || (pslverr !== t.err)) begin
      bad_count++;
      $display("wrong value %s expected %h/%b seen %h/%b", t.nm, t.exp & t.mask, t.err, prdata & t.mask, pslverr);
    end
  end
  initial begin
    logic [25:0] ra;
    logic [31:0] q;
    void'($urandom(13538));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    check("ctrl", `FSER_CTRL_OFF, 32'h0, 32'h1F, 1'b0);
    check("status", `FSER_STAT_OFF, 32'h40, 32'h3FF, 1'b0);
    check("unmapped", 8'h1C, 32'h0, 32'h0, 1'b1);
    check("misaligned", 8'h06, 32'h0, 32'h0, 1'b1);
    for (int i = 0; i < 4; i++) begin
      ra = 26'($urandom);
      run(`FSER_OP_READ, ra, 16'h0000);
      check("rdata", `FSER_RDATA_OFF, {16'h0000, ra[15:0] ^ 16'h5A5A}, 32'hFFFF, 1'b0);
    end
    fser_flash_model_inst.mode <= 3'h1;
    run(`FSER_OP_READ, ra, 16'h0000);
    xfer(1'b0, `FSER_RDATA_OFF, 32'h0, 1'b0, q);
    run(`FSER_OP_READ, ra, 16'h0000);
    check("erase poll", `FSER_RDATA_OFF, {24'h0, 1'b0, ~q[6], 3'b001, ~q[2], 2'b00}, 32'hEE, 1'b0);
    check("erase pin", `FSER_STAT_OFF, 32'h0, 32'h40, 1'b0);
    for (int k = 0; k < 2; k++) begin
      fser_flash_model_inst.mode <= k ? 3'h3 : 3'h2;
      run(`FSER_OP_POLL, ra, 16'h0000);
      check("err status", `FSER_STAT_OFF, {22'h0, k ? 2'h2 : 2'h1, 3'b000, k == 1, k == 0, 3'b110}, 32'h37F, 1'b0);
      run(`FSER_OP_SRREAD, ra, 16'h0000);
      check("sreg", `FSER_SREG_OFF, k ? 32'h98 : 32'hA0, 32'hFE, 1'b0);
      run(`FSER_OP_CMD, ra, k ? `FSER_CMD_RESET : `FSER_CMD_ABRST);
      check("refused", `FSER_STAT_OFF, 32'h22, 32'h23, 1'b0);
      run(`FSER_OP_CMD, ra, k ? `FSER_CMD_SRCLR : `FSER_CMD_RESET);
      check("cleared", `FSER_STAT_OFF, 32'h42, 32'h363, 1'b0);
    end
    // auto clear: timeout found, reset written by the controller itself
    fser_flash_model_inst.mode <= 3'h2;
    run({1'b1, `FSER_OP_POLL}, ra, 16'h0000);
    check("auto clear", `FSER_STAT_OFF, 32'h46, 32'h37F, 1'b0);
    fser_flash_model_inst.mode <= 3'h4;
    run(`FSER_OP_SRREAD, ra, 16'h0000);
    check("prot sreg", `FSER_SREG_OFF, 32'h0, 32'h80, 1'b0);
    check("prot status", `FSER_STAT_OFF, 32'h300, 32'h340, 1'b0);
    run(`FSER_OP_CMD, ra, `FSER_CMD_RESET);
    check("prot refused", `FSER_STAT_OFF, 32'h22, 32'h23, 1'b0);
    fser_flash_model_inst.mode <= 3'h5;
    run(`FSER_OP_SRREAD, ra, 16'h0000);
    check("prot done sreg", `FSER_SREG_OFF, 32'h92, 32'hFE, 1'b0);
    run(`FSER_OP_READ, ra, 16'h0000);
    check("prot done data", `FSER_RDATA_OFF, {16'h0000, ra[15:0] ^ 16'h5A5A}, 32'hFFFF, 1'b0);
    fser_flash_model_inst.mode <= 3'h6;
    run(`FSER_OP_POLL, ra, 16'h0000);
    check("esusp status", `FSER_STAT_OFF, 32'h42, 32'h47, 1'b0);
    check("esusp poll", `FSER_RDATA_OFF, 32'h80, 32'hA8, 1'b0);
    fser_flash_model_inst.mode <= 3'h0;
    wr(`FSER_SUSP_OFF, {5'h00, ra, 1'b1});
    run(`FSER_OP_READ, ra, 16'h0000);
    check("susp refused", `FSER_STAT_OFF, 32'h22, 32'h23, 1'b0);
    ra = ra ^ 26'h100;
    run(`FSER_OP_READ, ra, 16'h0000);
    check("susp other", `FSER_RDATA_OFF, {16'h0000, ra[15:0] ^ 16'h5A5A}, 32'hFFFF, 1'b0);
    print_verdict();
  end
endmodule // testbench
